/* File: hdl/float_load_execution.sv */
// Execution sequencer for the six floating-point load instructions
`timescale 1ns/1ps
`include "float_load_cfg.svh"

// Cycle plan, counted from the edge that takes start_i
//    Short register load: read at 1, write at 2, done at 3
//    Long register load: reads at 1 and 2, writes at 4 and 6, done at 7
//    Storage loads: request at 1, answer taken from cycle 2 on
//    Short storage load: write after the answer, then done
//    Long storage load: odd write, move, even write, then done
// Read data is taken in the cycle the read strobe stands
// Storage data is taken in the cycle its valid pulse stands
// A specification check ends the load at 2 with no write
// The next start may come in the cycle done_o stands
// A start while busy is ignored, not queued
// Unserved opcodes are ignored and raise nothing
// Condition code moves only at end-op of a test load
// Sign and zero flags hold until the next load that sets them
// Port widths fixed: four-bit fields, 24-bit addresses
// Alignment: word needs two low zeros, doubleword three
// Word pick: address bit 21 counted from the top, i.e. bit 2
// Short zero test: low 24 bits of the word
// Long zero test: high fraction and whole low word
// Sign flag: top bit of the high word
// Trade-off: one write port, so long loads take two writes
// Trade-off: staging register kept so the high word waits its turn
// Limitation: a storage answer outside the wait is dropped

module float_load_execution #(
   parameter int unsigned FPR_COUNT = 16
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Instruction start
   input wire logic start_i,
   input wire logic [7:0] opcode_i,
   input wire logic [3:0] first_register_field_i,
   input wire logic [3:0] second_register_field_i,
   input wire logic [23:0] base_addr_i,
   input wire logic [23:0] displacement_i,
   input wire logic set_condition_microorder_i,
   // Float register read port
   output logic float_register_re_o,
   output logic [3:0] float_register_raddr_o,
   input wire logic [31:0] float_register_rdata_i,
   // Float register write port
   output logic float_register_we_o,
   output logic [3:0] float_register_waddr_o,
   output logic [31:0] float_register_wdata_o,
   // Main storage
   output logic mem_req_o,
   output logic [23:0] mem_addr_o,
   input wire logic mem_valid_i,
   input wire logic [63:0] storage_data_out_i,
   // Status
   output logic busy_o,
   output logic done_o,
   output logic spec_intr_o,
   output logic [1:0] condition_code_o,
   output logic sign_flag_o,
   output logic zero_flag_o
);
   import float_load_pkg::*;

   // Register file has sixteen entries addressed by four bits
   // Fields are four bits wide, so no other count can be served
   if (FPR_COUNT != 16) begin : g_bad_fpr_count
      $error("FPR_COUNT must be 16");
   end

   // Whole block state
   float_load_state_t q;
   // Next state
   float_load_state_t d;
   // Decoded opcode classes
   logic is_short_rr;
   logic is_short_st;
   logic is_long_rr;
   logic is_long_st;
   logic is_test;
   logic is_load;
   // Odd partner register of a pair
   logic [3:0] first_odd;
   logic [3:0] second_odd;
   // Selected storage word
   logic [31:0] mem_word;
   // Specification check result for the latched instruction
   logic spec_fail;
   // Incoming opcode is one of the storage forms
   logic storage_start;
   // Effective address of the incoming instruction
   logic [23:0] start_addr;
   // Fraction of the word on the read port is zero
   logic rd_frac_zero;
   // Whole word on the read port is zero
   logic rd_word_zero;

   // Opcode decode on the latched instruction
   // Test loads share the path of their plain loads
   always_comb begin
      is_short_rr = (q.opcode == `OP_LOAD_SHORT_REGREG) || (q.opcode == `OP_LOAD_TEST_SHORT);
      is_long_rr = (q.opcode == `OP_LOAD_LONG_REGREG) || (q.opcode == `OP_LOAD_TEST_LONG);
      is_short_st = (q.opcode == `OP_LOAD_SHORT_STORAGE);
      is_long_st = (q.opcode == `OP_LOAD_LONG_STORAGE);
      is_test = (q.opcode == `OP_LOAD_TEST_SHORT) || (q.opcode == `OP_LOAD_TEST_LONG);
      // Pair partner; an even field names the high word
      first_odd = q.first_reg | 4'h1;
      second_odd = q.second_reg | 4'h1;
      // word and doubleword alignment
      // Odd fields of a long register pair are refused as well
      spec_fail = (is_short_st && (q.eff_addr[1:0] != 2'h0))
         || (is_long_st && (q.eff_addr[2:0] != 3'h0))
         || (is_long_rr && (q.first_reg[0] || q.second_reg[0]));
      // Fraction is the low 24 bits; sign and characteristic ignored
      rd_frac_zero = (float_register_rdata_i[23:0] == 24'h000000);
      // Low word of a long operand is all fraction
      rd_word_zero = (float_register_rdata_i == 32'h00000000);
   end

   // Incoming opcode is one this block serves
   assign is_load = (opcode_i == `OP_LOAD_SHORT_REGREG) || (opcode_i == `OP_LOAD_TEST_SHORT)
      || (opcode_i == `OP_LOAD_LONG_REGREG) || (opcode_i == `OP_LOAD_TEST_LONG)
      || (opcode_i == `OP_LOAD_SHORT_STORAGE) || (opcode_i == `OP_LOAD_LONG_STORAGE);

   // Address and form of the incoming instruction
   always_comb begin
      // effective address sum
      // Carry out of the 24-bit sum is dropped on purpose
      start_addr = 24'(base_addr_i + displacement_i);
      // Storage forms fetch, register forms read the file
      storage_start = (opcode_i == `OP_LOAD_SHORT_STORAGE) || (opcode_i == `OP_LOAD_LONG_STORAGE);
   end

   // word select by bit
   // Address bit 21 counts from the msb of a 24-bit address, i.e. bit 2 here
   assign mem_word = q.eff_addr[`ADDR_MSB - `WORD_SEL_BIT] ? storage_data_out_i[31:0]
      : storage_data_out_i[63:32];

   // Next-state and datapath sequencing
   always_comb begin
      d = q;
      // Strobes default low every cycle
      // so each strobe stands one cycle, the read strobe two in a long register load
      d.fpr_we = 1'b0;
      d.fpr_re = 1'b0;
      d.mem_req = 1'b0;
      d.done = 1'b0;
      d.spec_intr = 1'b0;
      unique case (q.state)
         // Wait for an instruction
         ST_IDLE: begin
            // Latch the instruction; other opcodes stay idle
            if (start_i && is_load) begin
               d.opcode = opcode_i;
               d.first_reg = first_register_field_i;
               d.second_reg = second_register_field_i;
               d.busy = 1'b1;
               // hold effective address
               // Kept for the alignment test and the word pick
               d.eff_addr = start_addr;
               if (storage_start) begin
                  // request second operand
                  // Issued before the check; a refused load drops the answer
                  d.mem_req = 1'b1;
                  d.mem_addr = start_addr;
               end else begin
                  // Register forms start with the source named by the second field
                  // read source register named by the second field
                  d.fpr_re = 1'b1;
                  d.fpr_raddr = second_register_field_i;
               end
               d.state = ST_SPEC;
            end
         end
         // Specification test at start of execution
         ST_SPEC: begin
            // Register forms: the source word stands on the read port now
            if (!is_short_st && !is_long_st) begin
               d.staging = float_register_rdata_i;
               d.transfer = float_register_rdata_i;
            end
            // suppress on check
            // No write, no flag and no code change on this path
            if (spec_fail) begin
               // Interrupt and done stand together for one cycle
               d.spec_intr = 1'b1;
               d.done = 1'b1;
               d.busy = 1'b0;
               d.state = ST_IDLE;
            end else if (is_short_rr) begin
               d.fpr_we = 1'b1;
               d.fpr_waddr = q.first_reg;
               d.fpr_wdata = float_register_rdata_i;
               d.sign_flag = float_register_rdata_i[31];
               d.zero_flag = rd_frac_zero;
               // Nothing left to move; go set the code
               d.state = ST_END_OP;
            end else if (is_long_rr) begin
               d.fpr_re = 1'b1;
               d.fpr_raddr = second_odd;
               d.sign_flag = float_register_rdata_i[31];
               // High fraction starts the zero test
               d.zero_flag = rd_frac_zero;
               d.state = ST_READ_ODD;
            end else begin
               // Storage forms wait for the doubleword
               d.state = ST_WAIT_DATA;
            end
         end
         // Storage doubleword arrives
         ST_WAIT_DATA: begin
            // Nothing moves until the valid pulse
            if (mem_valid_i) begin
               if (is_short_st) begin
                  // chosen word to transfer
                  // Transfer and write share the word in one cycle
                  d.transfer = mem_word;
                  d.fpr_we = 1'b1;
                  d.fpr_waddr = q.first_reg;
                  d.fpr_wdata = mem_word;
                  d.state = ST_END_OP;
               end else begin
                  // whole doubleword staged
                  // Left word is the high-order half
                  d.staging = storage_data_out_i[63:32];
                  d.transfer = storage_data_out_i[31:0];
                  d.state = ST_WRITE_ODD;
               end
            end
         end
         // Low word from odd source register
         ST_READ_ODD: begin
            d.transfer = float_register_rdata_i;
            d.zero_flag = q.zero_flag && rd_word_zero;
            d.state = ST_WRITE_ODD;
         end
         ST_WRITE_ODD: begin
            // Low word always lands first
            d.fpr_we = 1'b1;
            // Odd partner of the destination pair
            d.fpr_waddr = first_odd;
            d.fpr_wdata = q.transfer;
            d.state = ST_MOVE_HIGH;
         end
         ST_MOVE_HIGH: begin
            // High word waited in staging
            d.transfer = q.staging;
            d.state = ST_WRITE_EVEN;
         end
         ST_WRITE_EVEN: begin
            d.fpr_we = 1'b1;
            // Even register of the destination pair
            d.fpr_waddr = q.first_reg;
            d.fpr_wdata = q.transfer;
            d.state = ST_END_OP;
         end
         // Normal end-op cycle
         ST_END_OP: begin
            if (set_condition_microorder_i && is_test) begin
               if (q.zero_flag) begin
                  d.condition_code = `CC_ZERO;
               end else if (q.sign_flag) begin
                  d.condition_code = `CC_MINUS;
               end else begin
                  d.condition_code = `CC_PLUS;
               end
            end
            // Done and the new code show in the same cycle
            d.done = 1'b1;
            // Idle already, so a start may come with done
            d.busy = 1'b0;
            d.state = ST_IDLE;
         end
      endcase
   end

   // State register for the whole block
   // Reset clears every strobe and the condition code
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         // Constants only in the reset branch
         q <= '0;
         q.state <= ST_IDLE;
         q.condition_code <= `CC_RESET;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flip-flops
   // Read port; data is taken while the strobe stands
   assign float_register_re_o = q.fpr_re;
   assign float_register_raddr_o = q.fpr_raddr;
   // writes reach first operand only
   // Write addresses come only from the first field, so the source stays intact
   assign float_register_we_o = q.fpr_we;
   assign float_register_waddr_o = q.fpr_waddr;
   assign float_register_wdata_o = q.fpr_wdata;
   // Storage request; address holds until the next request
   assign mem_req_o = q.mem_req;
   assign mem_addr_o = q.mem_addr;
   // Status pulses and levels
   assign busy_o = q.busy;
   assign done_o = q.done;
   assign spec_intr_o = q.spec_intr;
   assign condition_code_o = q.condition_code;
   assign sign_flag_o = q.sign_flag;
   assign zero_flag_o = q.zero_flag;
endmodule // float_load_execution

/* File: hdl/float_load_cfg.svh */
// Constants for the floating-point load execution block
`ifndef FLOAT_LOAD_CFG_SVH
`define FLOAT_LOAD_CFG_SVH
`define OP_LOAD_SHORT_REGREG 8'h38
`define OP_LOAD_SHORT_STORAGE 8'h78
`define OP_LOAD_LONG_REGREG 8'h28
`define OP_LOAD_LONG_STORAGE 8'h68
`define OP_LOAD_TEST_SHORT 8'h32
`define OP_LOAD_TEST_LONG 8'h22
`define WORD_SEL_BIT 21
`define ADDR_MSB 23
`define CC_ZERO 2'h0
`define CC_MINUS 2'h1
`define CC_PLUS 2'h2
`define CC_RESET 2'h0
`endif

/* File: hdl/float_load_pkg.sv */
// Types for the floating-point load execution block
package float_load_pkg;
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_SPEC = 8'h02,
      ST_WAIT_DATA = 8'h04,
      ST_READ_ODD = 8'h08,
      ST_WRITE_ODD = 8'h10,
      ST_MOVE_HIGH = 8'h20,
      ST_WRITE_EVEN = 8'h40,
      ST_END_OP = 8'h80
   } exec_state_t;
   typedef struct packed {
      exec_state_t state;
      logic [7:0] opcode;
      logic [3:0] first_reg;
      logic [3:0] second_reg;
      logic [23:0] eff_addr;
      logic [31:0] staging;
      logic [31:0] transfer;
      logic sign_flag;
      logic zero_flag;
      logic [1:0] condition_code;
      logic spec_intr;
      logic done;
      logic fpr_we;
      logic [3:0] fpr_waddr;
      logic [31:0] fpr_wdata;
      logic fpr_re;
      logic [3:0] fpr_raddr;
      logic mem_req;
      logic [23:0] mem_addr;
      logic busy;
   } float_load_state_t;
endpackage

/* File: tb/float_load_execution_assertions.sv */
// Port-level assertions for the floating-point load block
`timescale 1ns/1ps
`include "float_load_cfg.svh"
module float_load_checker (
   // Watched ports of the load block
   input wire logic sys_clk_i, reset_n_i, start_i, busy_o, done_o, spec_intr_o, sign_flag_o, zero_flag_o,
   input wire logic float_register_re_o, float_register_we_o, mem_req_o,
   input wire logic [7:0] opcode_i,
   input wire logic [3:0] first_register_field_i, second_register_field_i,
   input wire logic [3:0] float_register_raddr_o, float_register_waddr_o,
   input wire logic [23:0] base_addr_i, displacement_i, mem_addr_o,
   input wire logic [1:0] condition_code_o
);
   logic [7:0] op_q; // Opcode in flight
   logic [3:0] r1_q, r2_q; // Its register fields
   logic [23:0] ea_q; // Its effective address
   wire tst = op_q inside {`OP_LOAD_TEST_SHORT, `OP_LOAD_TEST_LONG};
   wire lng = op_q inside {`OP_LOAD_LONG_REGREG, `OP_LOAD_TEST_LONG, `OP_LOAD_LONG_STORAGE};
   wire sto = op_q[6]; // Storage forms carry opcode bit 6
   // Capture the instruction as it is taken; a start in the done cycle counts
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {op_q, r1_q, r2_q, ea_q} <= '0;
      end else if (start_i && (!busy_o || done_o)) begin
         {op_q, r1_q, r2_q} <= {opcode_i, first_register_field_i, second_register_field_i};
         ea_q <= base_addr_i + displacement_i;
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   a_spec_no_write: assert property (spec_intr_o |-> done_o && !float_register_we_o && !$past(float_register_we_o))
      else $error("specification check wrote or lacked done");
   a_cc_only_test: assert property ($changed(condition_code_o) |-> done_o && tst)
      else $error("condition code moved outside a test load end");
   a_cc_value: assert property (done_o && tst && $changed(condition_code_o) |->
      condition_code_o == (zero_flag_o ? `CC_ZERO : sign_flag_o ? `CC_MINUS : `CC_PLUS))
      else $error("condition code disagrees with flags");
   a_word_align: assert property (done_o && op_q == `OP_LOAD_SHORT_STORAGE |-> spec_intr_o == (ea_q[1:0] != 2'h0))
      else $error("word alignment check wrong");
   a_dword_align: assert property (done_o && op_q == `OP_LOAD_LONG_STORAGE |-> spec_intr_o == (ea_q[2:0] != 3'h0))
      else $error("doubleword alignment check wrong");
   a_req_addr: assert property (mem_req_o |-> mem_addr_o == ea_q)
      else $error("storage request address wrong");
   a_read_source: assert property ($rose(busy_o) && !sto |-> float_register_re_o && float_register_raddr_o == r2_q)
      else $error("source register not read first");
   a_write_dest: assert property (float_register_we_o && !lng |-> float_register_waddr_o == r1_q)
      else $error("short load wrote wrong register");
   a_long_order: assert property (float_register_we_o && lng && !float_register_waddr_o[0] |->
      float_register_waddr_o == r1_q && $past(float_register_we_o, 2) && $past(float_register_waddr_o, 2) == (r1_q | 4'h1))
      else $error("long load pair order wrong");
   c_spec: cover property (done_o && spec_intr_o);
   c_minus: cover property (done_o && tst && condition_code_o == `CC_MINUS);
   c_long: cover property (float_register_we_o && lng);
endmodule // float_load_checker
bind float_load_execution float_load_checker chk (.*);

/* File: tb/storage_model.sv */
// Behavioural float registers and main storage facing the load block
`timescale 1ns/1ps
module storage_model (
   // Clock, reset, strobes and chosen storage latency
   input wire logic clk_i, rst_n_i, re_i, we_i, req_i,
   input wire logic [2:0] lat_i,
   // Addresses and data
   input wire logic [3:0] raddr_i, waddr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [23:0] addr_i,
   output logic [31:0] rdata_o,
   output logic valid_o,
   output logic [63:0] data_o
);
   logic [31:0] float_register [16]; // Register contents, preset by the bench
   logic [23:0] a_q; // Address of the pending fetch
   logic [2:0] cnt_q; // Cycles left before data returns
   // Data follows its address; inverted outside valid so stale data never matches
   assign data_o = {64{~valid_o}} ^ {a_q, 8'hc3, ~a_q, 8'h3c};
   // Read data stands while the strobe does; inverted otherwise so a late look fails
   assign rdata_o = re_i ? float_register[raddr_i] : ~float_register[raddr_i];
   // Writes land at the edge that ends the strobe cycle
   always @(posedge clk_i) begin
      if (we_i) float_register[waddr_i] <= wdata_i;
   end
   // Storage answers after the latency the bench picks, prompt or slow
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {valid_o, cnt_q, a_q} <= '0;
      end else begin
         valid_o <= cnt_q == 3'h1;
         if (req_i) {cnt_q, a_q} <= {lat_i, addr_i};
         else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
      end
   end
endmodule // storage_model

/* File: tb/testbench.sv */
// Self-checking bench for the floating-point load block
`timescale 1ns/1ps
`include "float_load_cfg.svh"
module testbench;
   // Inputs, driven at the falling edge
   logic sys_clk_i = 0, reset_n_i = 0, start_i = 0, set_condition_microorder_i = 0;
   logic [7:0] opcode_i = 8'h0;
   logic [3:0] first_register_field_i = 4'h0, second_register_field_i = 4'h0;
   logic [23:0] base_addr_i = 24'h0, displacement_i = 24'h0;
   // Outputs and partner answers
   logic float_register_re_o, float_register_we_o, mem_req_o, mem_valid_i, busy_o, done_o;
   logic spec_intr_o, sign_flag_o, zero_flag_o;
   logic [3:0] float_register_raddr_o, float_register_waddr_o;
   logic [31:0] float_register_rdata_i, float_register_wdata_o;
   logic [23:0] mem_addr_o;
   logic [63:0] storage_data_out_i;
   logic [1:0] condition_code_o, cc_e = 2'h0; // Expected code
   logic [31:0] fm [16]; // Expected register contents
   logic [7:0] ops [6] = '{`OP_LOAD_SHORT_REGREG, `OP_LOAD_SHORT_STORAGE, `OP_LOAD_LONG_REGREG,
      `OP_LOAD_LONG_STORAGE, `OP_LOAD_TEST_SHORT, `OP_LOAD_TEST_LONG};
   logic [2:0] lat = 3'h1;
   int n_mismatch = 0, samples_checked = 0, cyc = 0;
   float_load_execution uut (.*);
   storage_model mdl (.clk_i(sys_clk_i), .rst_n_i(reset_n_i), .re_i(float_register_re_o), .we_i(float_register_we_o),
      .req_i(mem_req_o), .lat_i(lat), .raddr_i(float_register_raddr_o), .waddr_i(float_register_waddr_o),
      .wdata_i(float_register_wdata_o), .addr_i(mem_addr_o), .rdata_o(float_register_rdata_i),
      .valid_o(mem_valid_i), .data_o(storage_data_out_i));
   initial forever #4 sys_clk_i = ~sys_clk_i;
   // Hang guard, far above 69 loads of at most 20 cycles
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
      samples_checked++;
      if (e !== s) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // One load, started at once so consecutive calls run back to back
   task automatic run(logic [7:0] op, logic [3:0] r1, logic [3:0] r2, logic [23:0] ea, logic sc);
      logic [63:0] d, w;
      logic sp, z, s, lg, ts;
      int n = 0;
      lg = op inside {`OP_LOAD_LONG_REGREG, `OP_LOAD_TEST_LONG, `OP_LOAD_LONG_STORAGE};
      ts = op inside {`OP_LOAD_TEST_SHORT, `OP_LOAD_TEST_LONG};
      w = {ea, 8'hc3, ~ea, 8'h3c};
      d = lg ? {fm[r2], fm[r2 | 4'h1]} : {32'h0, fm[r2]};
      sp = lg && (r1[0] | r2[0]);
      if (op == `OP_LOAD_SHORT_STORAGE) {sp, d} = {ea[1:0] != 2'h0, 32'h0, ea[2] ? w[31:0] : w[63:32]};
      if (op == `OP_LOAD_LONG_STORAGE) {sp, d} = {ea[2:0] != 3'h0, w};
      z = lg ? d[55:0] == 56'h0 : d[23:0] == 24'h0;
      s = lg ? d[63] : d[31];
      {start_i, opcode_i, first_register_field_i, second_register_field_i} = {1'b1, op, r1, r2};
      base_addr_i = 24'($urandom);
      displacement_i = ea - base_addr_i;
      set_condition_microorder_i = sc;
      lat = 3'($urandom_range(1, 4));
      @(negedge sys_clk_i) start_i = 0;
      chk("busy", 1, busy_o);
      while (done_o !== 1'b1 && n < 40) begin
         @(negedge sys_clk_i);
         n++;
      end
      chk("done", 1, done_o);
      chk("idle", 0, busy_o);
      chk("spec", sp, spec_intr_o);
      if (!sp) begin
         if (lg) fm[r1 | 4'h1] = d[31:0];
         fm[r1] = lg ? d[63:32] : d[31:0];
         if (ts && sc) cc_e = z ? `CC_ZERO : s ? `CC_MINUS : `CC_PLUS;
         if (ts) chk("flags", {s, z}, {sign_flag_o, zero_flag_o});
         if (op[6]) chk("addr", ea, mem_addr_o);
      end
      chk("cc", cc_e, condition_code_o);
      for (int i = 0; i < 16; i++) chk("fpr", fm[i], mdl.float_register[i]);
   endtask
   initial begin
      logic [7:0] op;
      logic [3:0] r1;
      logic [23:0] ea;
      void'($urandom(32'hda16));
      // Every fourth register has a zero fraction; register 9 is all zero, so pair 8/9 tests zero
      for (int i = 0; i < 16; i++) begin
         fm[i] = $urandom;
         if (i % 4 == 0) fm[i][23:0] = 24'h0;
         if (i == 9) fm[i] = 32'h0;
         mdl.float_register[i] = fm[i];
      end
      repeat (3) @(posedge sys_clk_i);
      @(negedge sys_clk_i) reset_n_i = 1;
      run(`OP_LOAD_SHORT_STORAGE, 4'h2, 4'h0, 24'h000104, 1);
      run(`OP_LOAD_SHORT_STORAGE, 4'h3, 4'h0, 24'h000100, 1);
      run(`OP_LOAD_SHORT_STORAGE, 4'h3, 4'h0, 24'h000102, 1);
      run(`OP_LOAD_LONG_STORAGE, 4'h6, 4'h0, 24'h000204, 1);
      run(`OP_LOAD_LONG_STORAGE, 4'h6, 4'h0, 24'h000208, 1);
      run(`OP_LOAD_TEST_LONG, 4'ha, 4'h8, 24'h0, 1);
      run(`OP_LOAD_LONG_REGREG, 4'h1, 4'h8, 24'h0, 1);
      run(`OP_LOAD_SHORT_REGREG, 4'h5, 4'h4, 24'h0, 1);
      run(`OP_LOAD_TEST_LONG, 4'h2, 4'h4, 24'h0, 1);
      // Unserved opcode is ignored
      {start_i, opcode_i} = {1'b1, 8'h33};
      @(negedge sys_clk_i) start_i = 0;
      chk("ignored", 0, busy_o);
      // Random mix; alignment favoured so both outcomes occur
      repeat (60) begin
         op = ops[$urandom_range(0, 5)];
         r1 = 4'($urandom);
         if (op == `OP_LOAD_LONG_STORAGE) r1[0] = 1'b0;
         ea = 24'($urandom);
         if ($urandom_range(0, 3) != 0) ea[1:0] = 2'h0;
         run(op, r1, 4'($urandom), ea, 1'($urandom));
      end
      wrap_up();
   end
endmodule // testbench
